/* File: include/lpt_pkg.sv */
// Package for the local-to-PCI address translation block
package lpt_pkg;
   // Address space codes held in entry bits 1:0
   localparam logic [1:0] LPT_SPACE_MEM32 = 2'h0;
   localparam logic [1:0] LPT_SPACE_MEM64 = 2'h1;
   localparam logic [1:0] LPT_SPACE_IO = 2'h2;
   localparam logic [1:0] LPT_SPACE_CFG = 2'h3;
   // Entry field positions
   localparam int LPT_SPACE_LSB = 0;
   localparam int LPT_SPACE_MSB = 1;
   // Configuration address fields
   localparam int LPT_CFG_BUS_LSB = 16;
   localparam int LPT_CFG_BUS_MSB = 23;
   localparam int LPT_CFG_DEV_LSB = 11;
   localparam int LPT_CFG_DEV_MSB = 15;
   localparam int LPT_CFG_ONEHOT_LSB = 11;
   localparam logic [1:0] LPT_CFG_TYPE0 = 2'h0;
   localparam logic [1:0] LPT_CFG_TYPE1 = 2'h1;
   // APB register map (byte offsets); table entries occupy a window
   localparam logic [11:0] LPT_REG_CTRL = 12'h000;
   localparam logic [11:0] LPT_REG_STATUS = 12'h004;
   localparam logic [11:0] LPT_REG_TABLE_BASE = 12'h800;
   localparam int LPT_TABLE_SEL_BIT = 11;
   // Reset values
   localparam logic [31:0] LPT_CTRL_RESET = 32'h0000_0000;
   // Control bit: translation enable
   localparam int LPT_CTRL_EN_BIT = 0;
   // Translated request carrier
   typedef struct packed {
      logic [63:0] addr;
      logic [1:0] space;
      logic dac;
      logic [7:0] be;
   } lpt_req_t;
endpackage

/* File: src/lpt_onehot.sv */
// One-hot decoder for configuration device numbers
`timescale 1ns/10ps
`default_nettype none
module lpt_onehot #(
   parameter int IN_W = 5,
   parameter int OUT_W = 21
) (
   input wire logic [IN_W-1:0] code,
   output logic [OUT_W-1:0] onehot
);
   // One bit per device number, beyond range gives zero
   always_comb begin
      onehot = '0;
      for (int i = 0; i < OUT_W; i++) begin
         if (code == IN_W'(i)) begin
            onehot[i] = 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: src/lpt_translate.sv */
// Local-to-PCI address translation table with APB access
// Contract
// - Low local address bits pass unchanged; high bits index the table.
// - Upper PCI address bits come from the selected entry.
// - One size parameter sets entry count and pass-through width.
// - Each entry holds a two-bit space code in bits 1:0.
// - Code 00 gives a 32-bit memory access, upper bits ignored.
// - Code 01 gives a 64-bit memory access with dual address cycle.
// - Code 01 only storable with 64-bit data path, except as a fixed table entry.
// - Code 10 targets I/O space with low-address rewrite.
// - Code 11 targets configuration space as type 1 address first.
// - I/O address bits 2:0 (bits 1:0 on a 32-bit data path) point at first enabled byte.
// - I/O address bits 31:3 stay as translated.
// - Bus number zero gives type 0, bits 1:0 forced to 00.
// - Type 0 passes bits 10:2 unchanged.
// - Type 0 bits 31:11 are one-hot of device number.
// - Type 0 ignores incoming bits 31:24.
// - Nonzero bus gives type 1, bits 1:0 forced 01.
// - Dynamic table entries writable at run time over the register port.
// - Dynamic table loads no preset contents at reset.
// - Fixed table is read-only storage, translating identically.
`timescale 1ns/10ps
`default_nettype none
module lpt_translate
   import lpt_pkg::*;
#(
   parameter int LOC_AW = 32,
   parameter int PASS_W = 20,
   parameter int PCI_DATA64 = 1,
   parameter int DYNAMIC = 1,
   parameter logic [63:0] FIXED_TABLE [0:(1<<(LOC_AW-PASS_W))-1] = '{default: 64'h0}
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic req_valid,
   input wire logic [LOC_AW-1:0] req_addr,
   input wire logic [7:0] req_be,
   output logic out_valid,
   output lpt_req_t out_req
);
   localparam int IDX_W = LOC_AW - PASS_W;
   localparam int ENTRIES = 1 << IDX_W;

   ////////////////////////////////////////////////////////////////////////
   // Storage and control
   logic [63:0] table_q [0:ENTRIES-1];
   logic [31:0] ctrl_q;
   logic [31:0] wr_count_q;
   logic [63:0] entry;
   logic [IDX_W-1:0] idx;
   logic [IDX_W:0] reg_idx;
   logic reg_hi;
   logic apb_wr;
   logic tab_hit;
   logic [31:0] wval;

   assign apb_wr = psel & penable & pwrite;
   assign tab_hit = paddr[LPT_TABLE_SEL_BIT];
   assign reg_idx = (IDX_W+1)'(paddr[10:2]);
   assign reg_hi = reg_idx[0];

   // Space code 01 is stored as code 00 on a 32-bit data path
   always_comb begin
      wval = pwdata;
      if (!reg_hi && PCI_DATA64 == 0 && pwdata[LPT_SPACE_MSB:LPT_SPACE_LSB] == LPT_SPACE_MEM64) begin
         wval[LPT_SPACE_MSB:LPT_SPACE_LSB] = LPT_SPACE_MEM32;
      end
   end

   // Table storage, no reset on entries
   generate
      if (DYNAMIC != 0) begin : g_dyn
         always_ff @(posedge pclk) begin
            if (apb_wr && tab_hit) begin
               if (reg_hi) begin
                  table_q[reg_idx[IDX_W:1]][63:32] <= wval;
               end else begin
                  table_q[reg_idx[IDX_W:1]][31:0] <= wval;
               end
            end
         end
      end else begin : g_fix
         always_comb begin
            for (int i = 0; i < ENTRIES; i++) begin
               table_q[i] = FIXED_TABLE[i];
            end
         end
      end
   endgenerate

   // Control register and write counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= LPT_CTRL_RESET;
         wr_count_q <= 32'h0;
      end else if (apb_wr) begin
         if (!tab_hit && paddr == LPT_REG_CTRL) begin
            ctrl_q <= pwdata;
         end
         if (tab_hit && DYNAMIC != 0) begin
            wr_count_q <= wr_count_q + 32'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB read path, zero-wait
   assign pready = 1'b1;
   always_comb begin
      prdata = 32'h0;
      pslverr = 1'b0;
      if (psel && penable) begin
         if (tab_hit) begin
            prdata = reg_hi ? table_q[reg_idx[IDX_W:1]][63:32] : table_q[reg_idx[IDX_W:1]][31:0];
         end else if (paddr == LPT_REG_CTRL) begin
            prdata = ctrl_q;
         end else if (paddr == LPT_REG_STATUS) begin
            prdata = wr_count_q;
         end else begin
            pslverr = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Translation path
   logic [63:0] xa;
   logic [1:0] space;
   logic [2:0] io_low;
   logic [20:0] dev_hot;

   assign idx = req_addr[LOC_AW-1:PASS_W];
   assign entry = table_q[idx];
   assign space = entry[LPT_SPACE_MSB:LPT_SPACE_LSB];

   lpt_onehot #(.IN_W(5), .OUT_W(21)) u_dev (
      .code(xa[LPT_CFG_DEV_MSB:LPT_CFG_DEV_LSB]),
      .onehot(dev_hot)
   );

   // First enabled byte lane
   always_comb begin
      io_low = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (req_be[i]) begin
            io_low = 3'(i);
         end
      end
   end

   // Base translation
   always_comb begin
      xa = {entry[63:PASS_W], req_addr[PASS_W-1:0]};
      if (space != LPT_SPACE_MEM64) begin
         xa[63:32] = 32'h0;
      end
   end

   // Space-dependent rewrite, combinational with the request
   always_comb begin
      out_req.addr = xa;
      out_req.space = space;
      out_req.dac = 1'b0;
      out_req.be = req_be;
      case (space)
         LPT_SPACE_MEM32: begin
            out_req.dac = 1'b0;
         end
         LPT_SPACE_MEM64: begin
            out_req.dac = 1'b1;
         end
         LPT_SPACE_IO: begin
            if (PCI_DATA64 != 0) begin
               out_req.addr[2:0] = io_low;
            end else begin
               out_req.addr[1:0] = io_low[1:0];
            end
         end
         LPT_SPACE_CFG: begin
            if (xa[LPT_CFG_BUS_MSB:LPT_CFG_BUS_LSB] == 8'h0) begin
               out_req.addr[31:11] = dev_hot;
               out_req.addr[1:0] = LPT_CFG_TYPE0;
            end else begin
               out_req.addr[1:0] = LPT_CFG_TYPE1;
            end
         end
         default: begin
            out_req.dac = 1'b0;
         end
      endcase
   end

   assign out_valid = req_valid & ctrl_q[LPT_CTRL_EN_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   // Type 0 low bits and one-hot for encodable devices
   AST_TYPE0: assert property (@(posedge pclk) disable iff (!presetn)
      (out_valid && space == LPT_SPACE_CFG && xa[23:16] == 8'h0 && xa[15:11] <= 5'h14)
      |-> out_req.addr[1:0] == 2'h0 && $onehot(out_req.addr[31:11]))
      else $error("type 0 encoding wrong");

   // Type 1 keeps bits 31:2, low bits 01
   AST_TYPE1: assert property (@(posedge pclk) disable iff (!presetn)
      (out_valid && space == LPT_SPACE_CFG && xa[23:16] != 8'h0) |-> out_req.addr[1:0] == 2'h1
      && out_req.addr[31:2] == xa[31:2])
      else $error("type 1 encoding wrong");

   // Type 0 register bits and device bit
   AST_DEV: assert property (@(posedge pclk) disable iff (!presetn)
      (out_valid && space == LPT_SPACE_CFG && xa[23:16] == 8'h0 && xa[15:11] <= 5'h14) |->
      out_req.addr[10:2] == xa[10:2] && out_req.addr[11 + xa[15:11]])
      else $error("type 0 device bits wrong");

   // Untranslated low bits
   AST_LOW: assert property (@(posedge pclk) disable iff (!presetn)
      out_valid && space != LPT_SPACE_CFG
      |-> out_req.addr[PASS_W-1:3] == req_addr[PASS_W-1:3])
      else $error("low bits not passed");

   // Dual address cycle only for code 01
   AST_DAC: assert property (@(posedge pclk) disable iff (!presetn)
      out_valid
      |-> out_req.dac == (space == LPT_SPACE_MEM64))
      else $error("dac flag wrong");

   // 32-bit memory drops the upper entry half
   AST_M32: assert property (@(posedge pclk) disable iff (!presetn)
      out_valid && space == LPT_SPACE_MEM32
      |-> out_req.addr[63:32] == 32'h0)
      else $error("upper bits not ignored");

   // I/O lane zero and untouched upper bits
   AST_IO: assert property (@(posedge pclk) disable iff (!presetn)
      out_valid && space == LPT_SPACE_IO && req_be[0] |-> out_req.addr[1:0] == 2'h0
      && out_req.addr[31:3] == xa[31:3])
      else $error("io rewrite wrong");

   // Low table word lands
   AST_WR: assert property (@(posedge pclk) disable iff (!presetn)
      apb_wr && tab_hit && !reg_hi && DYNAMIC != 0 ##1 1'b1 |->
      table_q[$past(reg_idx[IDX_W:1])][31:0] == $past(wval))
      else $error("table write lost");

   // No code 01 from a dynamic table on a 32-bit path
   AST_NO64: assert property (@(posedge pclk) disable iff (!presetn)
      PCI_DATA64 == 0 && out_valid
      |-> space != LPT_SPACE_MEM64 || DYNAMIC == 0)
      else $error("code 01 stored on 32-bit path");

   // I/O low bits name the first enabled lane
   AST_IO_LANE: assert property (@(posedge pclk) disable iff (!presetn)
      (out_valid && space == LPT_SPACE_IO && req_be != 8'h0 && PCI_DATA64 != 0) |-> req_be[out_req.addr[2:0]]
      && (req_be & ((8'h1 << out_req.addr[2:0]) - 8'h1)) == 8'h0)
      else $error("io lane wrong");

   // Bit 2 kept on a 32-bit path
   AST_IO_32: assert property (@(posedge pclk) disable iff (!presetn)
      out_valid && space == LPT_SPACE_IO && PCI_DATA64 == 0
      |-> out_req.addr[2] == xa[2])
      else $error("io bit 2 changed");

   // I/O is a single 32-bit address
   AST_IO_UP: assert property (@(posedge pclk) disable iff (!presetn)
      out_valid && space == LPT_SPACE_IO
      |-> out_req.addr[63:32] == 32'h0 && !out_req.dac)
      else $error("io upper bits set");

   // Configuration carries its space code
   AST_CFG_SP: assert property (@(posedge pclk) disable iff (!presetn)
      out_valid && space == LPT_SPACE_CFG
      |-> out_req.space == LPT_SPACE_CFG && out_req.addr[63:32] == 32'h0)
      else $error("config space wrong");

   // Type 0 upper byte from device code only
   AST_T0_IGN: assert property (@(posedge pclk) disable iff (!presetn)
      out_valid && space == LPT_SPACE_CFG && xa[23:16] == 8'h0 && xa[15:11] < 5'hd
      |-> out_req.addr[31:24] == 8'h0)
      else $error("type 0 upper byte leaked");

   // Devices beyond the select lines give no select
   AST_T0_WIDE: assert property (@(posedge pclk) disable iff (!presetn)
      out_valid && space == LPT_SPACE_CFG && xa[23:16] == 8'h0 && xa[15:11] > 5'h14
      |-> out_req.addr[31:11] == 21'h0)
      else $error("type 0 select for missing device");

   // Upper translated bits from the entry
   AST_HI: assert property (@(posedge pclk) disable iff (!presetn)
      out_valid && space != LPT_SPACE_CFG
      |-> out_req.addr[31:PASS_W] == entry[31:PASS_W])
      else $error("entry bits not used");

   // 64-bit memory keeps the upper entry half
   AST_M64: assert property (@(posedge pclk) disable iff (!presetn)
      out_valid && space == LPT_SPACE_MEM64
      |-> out_req.addr[63:32] == entry[63:32])
      else $error("upper entry half lost");

   // No request while translation is off
   AST_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_q[LPT_CTRL_EN_BIT]
      |-> !out_valid)
      else $error("request while disabled");

   // Fixed entry 0 never changes
   AST_FIX: assert property (@(posedge pclk) disable iff (!presetn)
      DYNAMIC == 0
      |-> table_q[0] == FIXED_TABLE[0])
      else $error("fixed entry changed");

   // Each table write is counted
   AST_CNT: assert property (@(posedge pclk) disable iff (!presetn)
      apb_wr && tab_hit && DYNAMIC != 0
      |=> wr_count_q == $past(wr_count_q) + 32'h1)
      else $error("table write not counted");

   // Table reads never error
   AST_RD: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pwrite && tab_hit
      |-> !pslverr)
      else $error("table read refused");

   // Control write lands
   AST_CTRL: assert property (@(posedge pclk) disable iff (!presetn)
      apb_wr && !tab_hit && paddr == LPT_REG_CTRL
      |=> ctrl_q == $past(pwdata))
      else $error("control write lost");

   // Main scenarios
   COV_CFG0: cover property (@(posedge pclk) out_valid && space == LPT_SPACE_CFG && xa[23:16] == 8'h0);
   COV_CFG1: cover property (@(posedge pclk) out_valid && space == LPT_SPACE_CFG && xa[23:16] != 8'h0);
   COV_IO: cover property (@(posedge pclk) out_valid && space == LPT_SPACE_IO);
   COV_DAC: cover property (@(posedge pclk) out_valid && out_req.dac);
   COV_WR: cover property (@(posedge pclk) apb_wr && tab_hit);
endmodule
`default_nettype wire

/* File: bench/lpt_pci_target.sv */
// Far-side model: PCI target latching each translated request
`timescale 1ns/10ps
`default_nettype none
module lpt_pci_target
   import lpt_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic out_valid,
   input wire lpt_req_t out_req,
   output lpt_req_t last_req_q
);
   // Latch request, single or dual address cycle alike
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_req_q <= '0;
      end else if (out_valid) begin
         last_req_q <= out_req;
      end
   end
endmodule
`default_nettype wire

/* File: bench/test_local_to_pci_addr_translate.sv */
// Testbench: table setup over APB and translation checks on three builds
`timescale 1ns/10ps
`default_nettype none
module test_local_to_pci_addr_translate
   import lpt_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic req_valid = 1'b0;
   logic [31:0] req_addr = 32'h0;
   logic [7:0] req_be = 8'h0;
   logic [31:0] prdata [3];
   logic pready [3];
   logic pslverr [3];
   logic out_valid [3];
   lpt_req_t out_req [3];
   lpt_req_t last_req;
   logic [31:0] rd [3];
   logic er [3];
   int fail_count = 0;
   int check_count = 0;
   int cyc = 0;
   logic [63:0] tab [4] = '{64'h0000_00ab_3000_0000, 64'h0000_0012_5000_0001, 64'h7000_0002, 64'h3};
   logic [31:0] ra [7] = '{32'h0123_4567, 32'h1abc_def4, 32'h2000_0100, 32'h2000_0007,
      32'h3000_1004, 32'h3000_f800, 32'h3005_0804};
   logic [7:0] rb [7] = '{8'h0f, 8'h01, 8'h10, 8'h80, 8'h0f, 8'h0f, 8'h0f};

   always #20 pclk = ~pclk;

   // Builds: 64-bit dynamic, 32-bit dynamic, 64-bit fixed
   for (genvar g = 0; g < 3; g++) begin : g_dut
      lpt_translate #(.PASS_W(28), .PCI_DATA64(g != 1), .DYNAMIC(g != 2),
         .FIXED_TABLE('{default: 64'h4000_0002})) i_dut (
         .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
         .paddr(paddr), .pwdata(pwdata), .prdata(prdata[g]), .pready(pready[g]), .pslverr(pslverr[g]),
         .req_valid(req_valid), .req_addr(req_addr), .req_be(req_be), .out_valid(out_valid[g]),
         .out_req(out_req[g]));
   end

   lpt_pci_target i_tgt (.pclk(pclk), .presetn(presetn), .out_valid(out_valid[0]), .out_req(out_req[0]),
      .last_req_q(last_req));

   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One APB transfer, shared by all builds
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready[0] !== 1'b1) begin
         @(posedge pclk);
      end
      for (int g = 0; g < 3; g++) begin
         rd[g] = prdata[g];
         er[g] = pslverr[g];
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Entry as stored by build g
   function automatic logic [63:0] ent(input int g, input int i);
      logic [63:0] e;
      e = (g == 2) ? 64'h4000_0002 : tab[i];
      if (g == 1 && e[1:0] == 2'h1) e[1:0] = 2'h0;
      return e;
   endfunction

   // Expected PCI address
   function automatic logic [63:0] xl(input logic [63:0] e, input logic [31:0] a, input logic [7:0] be,
      input logic d64);
      logic [31:0] t;
      int k;
      t = {e[31:28], a[27:0]};
      k = 0;
      while (k < 7 && !be[k]) k++;
      case (e[1:0])
         2'h1: return {e[63:32], t};
         2'h2: if (d64) t[2:0] = k[2:0]; else t[1:0] = k[1:0];
         2'h3: if (t[23:16] != 8'h0) t[1:0] = 2'h1; else t = {21'h1 << t[15:11], t[10:2], 2'h0};
         default: ;
      endcase
      return {32'h0, t};
   endfunction

   task automatic close_out();
      $display("Checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Cut a hang short
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count++;
         close_out();
      end
   end

   initial begin
      logic [63:0] e;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, LPT_REG_CTRL, 32'h0);
      chk("ctrl", rd[0], LPT_CTRL_RESET);
      req_valid <= 1'b1;
      @(posedge pclk);
      chk("valid_off", out_valid[0], 1'b0);
      apb(1'b0, 12'h100, 32'h0);
      for (int g = 0; g < 3; g++) chk("slverr", er[g], 1'b1);
      // Program table, then enable
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, LPT_REG_TABLE_BASE + 12'(8 * i), tab[i][31:0]);
         apb(1'b1, LPT_REG_TABLE_BASE + 12'(8 * i + 4), tab[i][63:32]);
      end
      apb(1'b1, LPT_REG_CTRL, 32'h1);
      apb(1'b0, LPT_REG_TABLE_BASE + 12'h8, 32'h0);
      for (int g = 0; g < 3; g++) chk("entry_lo", rd[g], ent(g, 1) & 64'hffff_ffff);
      apb(1'b0, LPT_REG_TABLE_BASE + 12'hc, 32'h0);
      for (int g = 0; g < 3; g++) chk("entry_hi", rd[g], ent(g, 1) >> 32);
      apb(1'b0, LPT_REG_STATUS, 32'h0);
      for (int g = 0; g < 3; g++) chk("status", rd[g], (g == 2) ? 64'h0 : 64'h8);
      // All four space codes on build 0, no code 01 on build 1, I/O only on build 2
      for (int j = 0; j < 7; j++) begin
         req_addr <= ra[j];
         req_be <= rb[j];
         @(posedge pclk);
         for (int g = 0; g < 3; g++) begin
            e = ent(g, int'(ra[j][31:28]));
            chk("valid", out_valid[g], 1'b1);
            chk("addr", out_req[g].addr, xl(e, ra[j], rb[j], g != 1));
            chk("space", out_req[g].space, e[1:0]);
            chk("dac", out_req[g].dac, e[1:0] == 2'h1);
            chk("be", out_req[g].be, rb[j]);
         end
      end
      @(posedge pclk);
      chk("tgt_addr", last_req.addr, xl(tab[3], ra[6], rb[6], 1'b1));
      close_out();
   end
endmodule
`default_nettype wire
